// File: shared/vic_pkg.sv
// Constants for the vectored interrupt controller
package vic_pkg;
  localparam int          NUM_SOURCES       = 6;
  localparam logic [7:0]  REQ_FLAGS_ADDR    = 8'hfa;
  localparam logic [7:0]  ENABLE_MASK_ADDR  = 8'hfb;
  localparam logic [7:0]  REQ_FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  ENABLE_MASK_RESET = 8'h00;
  localparam int          GLOBAL_EN_BIT     = 7;
  localparam int          RESERVED_MASK_BIT = 6;
  localparam logic [7:0]  REQ_VALID_BITS    = 8'h3f;
  localparam logic [7:0]  MASK_VALID_BITS   = 8'hbf;
  localparam logic [2:0]  NO_SOURCE         = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_VECTOR  = 3'b010,
    ST_SERVICE = 3'b100
  } vic_state_t;
endpackage

// File: tb/core_model.sv
// Processor core model: takes each vector after a chosen wait
`timescale 1ns/10ps
module core_model (
  input wire logic       sys_clk,
  input wire logic       vector_req_q,
  input wire logic [3:0] ack_wait,
  output logic           vector_ack
);
  int cnt = 0;
  initial vector_ack = 1'b0;
  // One-cycle ack, so a held request is never taken twice
  always @(posedge sys_clk) begin
    if (vector_req_q && !vector_ack && cnt >= ack_wait) begin
      vector_ack <= 1'b1;
      cnt <= 0;
    end else begin
      vector_ack <= 1'b0;
      cnt <= vector_req_q ? cnt + 1 : 0;
    end
  end
endmodule // core_model

// File: tb/vectored_interrupt_control_bench.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
module vectored_interrupt_control_bench;
  logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [5:0] source_req = 6'h00;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
  logic [2:0] ins = 3'h0, vector_id_q;
  logic [3:0] ack_wait = 4'h3;
  logic vector_ack, vector_req_q, in_service_q;
  int mismatches = 0, n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  vectored_interrupt_control dut (
    .sys_clk                    (sys_clk),
    .nrst                       (nrst),
    .source_req                 (source_req),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .global_enable_instruction  (ins[2]),
    .global_disable_instruction (ins[1]),
    .return_from_service        (ins[0]),
    .vector_ack                 (vector_ack),
    .reg_rdata_q                (reg_rdata_q),
    .vector_req_q               (vector_req_q),
    .vector_id_q                (vector_id_q),
    .in_service_q               (in_service_q)
  );
  core_model core (
    .sys_clk      (sys_clk),
    .vector_req_q (vector_req_q),
    .ack_wait     (ack_wait),
    .vector_ack   (vector_ack)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  // Source pulse rides with the write so both land on one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [5:0] s = 6'h00);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    source_req <= s;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    source_req <= 6'h00;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata_q, exp);
  endtask
  task automatic pulse(input logic [2:0] p);
    ins <= p;
    @(posedge sys_clk);
    ins <= 3'h0;
    @(posedge sys_clk);
  endtask
  task automatic serve(input logic [7:0] id);
    repeat (20) if (vector_req_q !== 1'b1) @(posedge sys_clk);
    chk({7'h0, vector_req_q}, 8'h01);
    chk({5'h0, vector_id_q}, id);
    repeat (20) if (vector_req_q !== 1'b0) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic t_regs;
    chk({5'h0, vector_id_q}, 8'h07);
    rd(8'hfa, 8'h00);
    rd(8'hfb, 8'h00);
    wr(8'hfb, 8'hff);
    rd(8'hfb, 8'hbf);
    wr(8'hfb, 8'h3f);
    wr(8'hfa, 8'hff);
    rd(8'hfa, 8'h3f);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    rd(8'hfa, 8'h3f);
    rd(8'hfb, 8'h3f);
    wr(8'hfa, 8'h02, 6'h01);
    rd(8'hfa, 8'h02);
    wr(8'hfa, 8'h00);
    $display("register test done");
  endtask
  task automatic t_hw;
    source_req <= 6'h24;
    @(posedge sys_clk);
    source_req <= 6'h00;
    rd(8'hfa, 8'h24);
    wr(8'hfb, 8'ha0);
    serve(8'h05);
    rd(8'hfb, 8'h20);
    rd(8'hfa, 8'h04);
    pulse(3'h1);
    rd(8'hfb, 8'ha0);
    chk({7'h0, vector_req_q}, 8'h00);
    wr(8'hfb, 8'h84);
    serve(8'h02);
    pulse(3'h1);
    $display("hardware test done");
  endtask
  task automatic t_nest;
    ack_wait <= 4'h0;
    wr(8'hfa, 8'h30);
    wr(8'hfb, 8'hb1);
    serve(8'h04);
    wr(8'hfb, 8'h01);
    pulse(3'h4);
    // Software raise keeps the source five request that is still pending
    wr(8'hfa, 8'h21);
    serve(8'h00);
    pulse(3'h1);
    chk({7'h0, in_service_q}, 8'h01);
    pulse(3'h2);
    wr(8'hfb, 8'h31);
    pulse(3'h1);
    serve(8'h05);
    pulse(3'h1);
    rd(8'hfb, 8'hb1);
    chk({7'h0, in_service_q}, 8'h00);
    $display("nesting test done");
  endtask
  task automatic t_reset;
    wr(8'hfa, 8'h02);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(8'hfb, 8'h00);
    rd(8'hfa, 8'h00);
    chk({5'h0, vector_id_q}, 8'h07);
    chk({7'h0, in_service_q}, 8'h00);
    $display("reset test done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_hw;
    t_nest;
    t_reset;
    finish_test;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
endmodule // vectored_interrupt_control_bench

// File: tb/vic_port_asserts.sv
// Port assertions for the vectored interrupt controller
`timescale 1ns/10ps
module vic_port_checker (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       reg_rd,
  input wire logic       vector_ack,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       vector_req_q,
  input wire logic       in_service_q,
  input wire logic [2:0] vector_id_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  reset_outputs_a: assert property (!$past(nrst) |-> !vector_req_q && !in_service_q
    && vector_id_q == vic_pkg::NO_SOURCE) else $error("outputs not at reset values");
  unmapped_read_a: assert property (reg_rd && reg_addr != vic_pkg::REQ_FLAGS_ADDR
    && reg_addr != vic_pkg::ENABLE_MASK_ADDR |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  req_reserved_a: assert property (reg_rd && reg_addr == vic_pkg::REQ_FLAGS_ADDR
    |=> reg_rdata_q[7:6] == 2'h0) else $error("request reserved bits set");
  mask_reserved_a: assert property (reg_rd && reg_addr == vic_pkg::ENABLE_MASK_ADDR
    |=> !reg_rdata_q[vic_pkg::RESERVED_MASK_BIT]) else $error("mask reserved bit set");
  vector_hold_a: assert property (vector_req_q && !vector_ack
    |=> vector_req_q && $stable(vector_id_q)) else $error("vector dropped early");
  ack_service_a: assert property (vector_req_q && vector_ack
    |=> !vector_req_q && in_service_q) else $error("ack did not start service");
  vector_range_a: assert property (vector_req_q |-> vector_id_q < 3'h6)
    else $error("vector id out of range");
  service_cause_a: assert property ($rose(in_service_q)
    |-> $past(vector_req_q && vector_ack)) else $error("service without ack");
endmodule // vic_port_checker

bind vectored_interrupt_control vic_port_checker port_chk (
  .sys_clk      (sys_clk),
  .nrst         (nrst),
  .reg_rd       (reg_rd),
  .vector_ack   (vector_ack),
  .reg_addr     (reg_addr),
  .reg_rdata_q  (reg_rdata_q),
  .vector_req_q (vector_req_q),
  .in_service_q (in_service_q),
  .vector_id_q  (vector_id_q)
);

// File: verilog/vectored_interrupt_control.sv
// Request and mask registers, priority resolution and vectoring for six sources
`timescale 1ns/10ps
// Contract
// - Mask register: bit 7 global enable, bit 6 reserved zero, bits 5..0 per source.
// - Request register records pending requests; a source request sets its bit.
// - Request bits 0..5 map to sources zero..five; bits 7,6 stay zero.
// - Reset clears mask and request registers to zero.
// - Software-set request bits are masked and serviced like hardware requests.
// - Request register readable and writable by software at any time.
// - Software write in same cycle as hardware set wins; hardware request lost.
// - Vector only if global enable, source enabled, no higher enabled request.
// - Higher priority may preempt once routine re-enables; software saves, restores mask.
module vectored_interrupt_control #(
  parameter int NUM_SOURCES = vic_pkg::NUM_SOURCES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic [NUM_SOURCES-1:0] source_req,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   global_enable_instruction,
  input  wire logic                   global_disable_instruction,
  input  wire logic                   return_from_service,
  input  wire logic                   vector_ack,
  output logic      [7:0]             reg_rdata_q,
  output logic                        vector_req_q,
  output logic      [2:0]             vector_id_q,
  output logic                        in_service_q
);
  vic_pkg::vic_state_t state_q;
  vic_pkg::vic_state_t state_d;

  logic [7:0] pending_request_flags;
  logic [7:0] request_enable_mask;
  logic [7:0] req_d;
  logic [7:0] mask_d;
  logic       req_load;
  logic       mask_load;
  logic       wr_req;
  logic       wr_mask;
  logic [NUM_SOURCES-1:0] enabled;
  logic [2:0] winner;
  logic       take;

  // Lowest index wins among enabled pending requests
  function automatic logic [2:0] pick_first(input logic [NUM_SOURCES-1:0] v);
    logic [2:0] r;
    r = vic_pkg::NO_SOURCE;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  assign wr_req  = reg_wr && addr_hit(reg_addr, vic_pkg::REQ_FLAGS_ADDR);
  assign wr_mask = reg_wr && addr_hit(reg_addr, vic_pkg::ENABLE_MASK_ADDR);

  // gate by global enable and per-source mask; software bits gated alike
  assign enabled = (request_enable_mask[vic_pkg::GLOBAL_EN_BIT] && state_q == vic_pkg::ST_IDLE)
                   ? (pending_request_flags[NUM_SOURCES-1:0] & request_enable_mask[NUM_SOURCES-1:0])
                   : '0;
  assign winner  = pick_first(enabled);
  assign take    = (winner != vic_pkg::NO_SOURCE);

  always_comb begin
    req_d    = pending_request_flags;
    req_load = 1'b1;
    if (wr_req) begin
      // Write wins outright; a same-cycle hardware set is dropped
      req_d = reg_wdata & vic_pkg::REQ_VALID_BITS;
    end else begin
      req_d[NUM_SOURCES-1:0] = pending_request_flags[NUM_SOURCES-1:0] | source_req;
      if (vector_req_q && vector_ack) begin
        req_d[vector_id_q] = 1'b0;
      end
      req_d = req_d & vic_pkg::REQ_VALID_BITS;
    end
  end

  always_comb begin
    mask_d    = request_enable_mask;
    mask_load = 1'b1;
    if (wr_mask) begin
      mask_d = reg_wdata & vic_pkg::MASK_VALID_BITS;
    end
    if (global_enable_instruction) begin
      mask_d[vic_pkg::GLOBAL_EN_BIT] = 1'b1;
    end
    if (global_disable_instruction) begin
      mask_d[vic_pkg::GLOBAL_EN_BIT] = 1'b0;
    end
    if (take) begin
      mask_d[vic_pkg::GLOBAL_EN_BIT] = 1'b0;
    end else if (return_from_service && in_service_q) begin
      mask_d[vic_pkg::GLOBAL_EN_BIT] = 1'b1;
    end
  end

  vic_reg8 #(
    .RESET_VALUE (vic_pkg::REQ_FLAGS_RESET)
  ) u_req (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .load      (req_load),
    .load_data (req_d),
    .value_q   (pending_request_flags)
  );

  vic_reg8 #(
    .RESET_VALUE (vic_pkg::ENABLE_MASK_RESET)
  ) u_mask (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .load      (mask_load),
    .load_data (mask_d),
    .value_q   (request_enable_mask)
  );

  always_comb begin
    case (state_q)
      vic_pkg::ST_IDLE:    state_d = take ? vic_pkg::ST_VECTOR : vic_pkg::ST_IDLE;
      vic_pkg::ST_VECTOR:  state_d = vector_ack ? vic_pkg::ST_SERVICE : vic_pkg::ST_VECTOR;
      vic_pkg::ST_SERVICE: state_d = vic_pkg::ST_IDLE;
      default:             state_d = vic_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= vic_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vector_req_q <= 1'b0;
      vector_id_q  <= vic_pkg::NO_SOURCE;
    end else if (take) begin
      vector_req_q <= 1'b1;
      vector_id_q  <= winner;
    end else if (vector_ack) begin
      vector_req_q <= 1'b0;
    end
  end

  // Depth counter of nested routines; preemption needs re-enable inside one
  logic [2:0] depth_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      depth_q      <= 3'h0;
      in_service_q <= 1'b0;
    end else begin
      if (vector_req_q && vector_ack && !(return_from_service && in_service_q)) begin
        depth_q      <= depth_q + 3'h1;
        in_service_q <= 1'b1;
      end else if (return_from_service && in_service_q
                   && !(vector_req_q && vector_ack)) begin
        depth_q      <= depth_q - 3'h1;
        in_service_q <= (depth_q != 3'h1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (addr_hit(reg_addr, vic_pkg::REQ_FLAGS_ADDR)) begin
        reg_rdata_q <= pending_request_flags;
      end else if (addr_hit(reg_addr, vic_pkg::ENABLE_MASK_ADDR)) begin
        reg_rdata_q <= request_enable_mask;
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end
endmodule // vectored_interrupt_control

// File: verilog/vic_reg8.sv
// Eight-bit register cell with reset value and write enable, stored value driven straight out on value_q
`timescale 1ns/10ps
module vic_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  output logic      [7:0] value_q
);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      value_q <= RESET_VALUE;
    end else if (load) begin
      value_q <= load_data;
    end
  end
endmodule // vic_reg8
